// File: logic/fsr_pkg.sv
// fsr_pkg: constants and state types for the suspend/resume and acceleration control block
// assumes a 10 MHz system clock and single-cycle command writes from the bus decoder
// Operation
// - suspend in select window suspends at once
// - erase suspend only for sector erase
// - running erase suspends within erase latency
// - suspended erase allows reads, programs elsewhere
// - reads of suspended sectors return status
// - program in erase suspend returns to suspend
// - identification read accepted in erase suspend
// - 0030h resumes erase; repeats ignored
// - 00B0h halts program within program latency
// - program suspend serves non-suspended sector reads
// - program suspend nests inside erase suspend
// - identification read in program suspend, then return
// - 0030h resumes program; repeats ignored
// - high voltage accel enters accelerated bypass mode
// - accel removed after operation returns normal
// - accel low locks every sector
// - polling bit 0 erasing, 1 done/suspended
package fsr_pkg;
    localparam logic [15:0] FSR_CMD_SUSPEND = 16'h00B0;
    localparam logic [15:0] FSR_CMD_RESUME  = 16'h0030;
    localparam int          FSR_CLK_NS      = 100;
    // latencies in ns
    localparam int          FSR_ERASE_SUSPEND_LATENCY_NS = 20000;
    localparam int          FSR_PROG_SUSPEND_LATENCY_NS  = 10000;
    localparam int          FSR_ERASE_SUSPEND_CYC = FSR_ERASE_SUSPEND_LATENCY_NS / FSR_CLK_NS;
    localparam int          FSR_PROG_SUSPEND_CYC  = FSR_PROG_SUSPEND_LATENCY_NS / FSR_CLK_NS;
    localparam logic [1:0]  FSR_ACCEL_LOW  = 2'h0;
    localparam logic [1:0]  FSR_ACCEL_NORM = 2'h1;
    localparam logic [1:0]  FSR_ACCEL_HIGH = 2'h2;
    localparam logic        FSR_POLL_BUSY  = 1'b0;
    localparam logic        FSR_POLL_DONE  = 1'b1;

    typedef enum logic [5:0] {
        FSR_IDLE      = 6'h01,
        FSR_SEL_WIN   = 6'h02,
        FSR_ERASING   = 6'h04,
        FSR_ERS_SUSP  = 6'h08,
        FSR_PROGRAM   = 6'h10,
        FSR_PRG_SUSP  = 6'h20
    } fsr_state_e;
endpackage

// File: logic/fsr_latency_timer.sv
// fsr_latency_timer: counts a suspend latency and pulses when the count runs out
// assumes start is a single-cycle pulse; a new start restarts the count
`timescale 1ns/1ps
module fsr_latency_timer #(
    parameter int CYCLES = 8
) (
    // clock and reset
    input  wire logic clk_sys_i,
    input  wire logic rst_b_i,
    // control
    input  wire logic start_i,
    input  wire logic abort_i,
    output logic      done_o
);
    localparam int W = $clog2(CYCLES + 1);
    logic [W-1:0] cnt_reg;
    logic         run_reg;

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            cnt_reg <= '0;
            run_reg <= 1'b0;
            done_o  <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (abort_i) begin
                run_reg <= 1'b0;
            end else if (start_i) begin
                cnt_reg <= W'(CYCLES - 1);
                run_reg <= 1'b1;
            end else if (run_reg) begin
                if (cnt_reg == '0) begin
                    run_reg <= 1'b0;
                    done_o  <= 1'b1;
                end else begin
                    cnt_reg <= cnt_reg - 1'b1;
                end
            end
        end
    end
endmodule // fsr_latency_timer

// File: logic/fsr_sector_mark.sv
// fsr_sector_mark: per-sector flags marking sectors chosen for erase or for program
// assumes set and clear strobes come from the sequencer, one sector at a time
`timescale 1ns/1ps
module fsr_sector_mark #(
    parameter int SECTORS = 16,
    parameter int SW      = 4
) (
    // clock and reset
    input  wire logic          clk_sys_i,
    input  wire logic          rst_b_i,
    // updates
    input  wire logic          set_i,
    input  wire logic [SW-1:0] set_sector_i,
    input  wire logic          clear_all_i,
    // query
    input  wire logic [SW-1:0] query_sector_i,
    output logic               hit_o
);
    logic [SECTORS-1:0] mark_reg;

    genvar g;
    generate
        for (g = 0; g < SECTORS; g++) begin : g_mark
            always_ff @(posedge clk_sys_i) begin
                if (!rst_b_i) begin
                    mark_reg[g] <= 1'b0;
                end else if (set_i && set_sector_i == SW'(g)) begin
                    mark_reg[g] <= 1'b1;
                end else if (clear_all_i) begin
                    mark_reg[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // registered read, one cycle after the query
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            hit_o <= 1'b0;
        end else begin
            hit_o <= mark_reg[query_sector_i];
        end
    end
endmodule // fsr_sector_mark

// File: logic/fsr_control.sv
// fsr_control: suspend/resume state for embedded erase and program, plus acceleration mode
// assumes commands arrive as decoded single-cycle writes; unlock sequences are decoded upstream
`timescale 1ns/1ps
module fsr_control #(
    parameter int SECTORS = 16,
    parameter int SW      = 4,
    parameter int BW      = 2,
    parameter int SEL_WIN_CYC = 500,
    parameter int ERS_CYC = fsr_pkg::FSR_ERASE_SUSPEND_CYC,
    parameter int PRG_CYC = fsr_pkg::FSR_PROG_SUSPEND_CYC
) (
    // clock and reset
    input  wire logic          clk_sys_i,
    input  wire logic          rst_b_i,
    // command writes
    input  wire logic          wr_i,
    input  wire logic [15:0]   wr_data_i,
    input  wire logic [BW-1:0] wr_bank_i,
    input  wire logic [SW-1:0] wr_sector_i,
    // embedded operation starts and ends from the algorithm engine
    input  wire logic          sector_erase_start_i,
    input  wire logic          chip_erase_start_i,
    input  wire logic          erase_sector_add_i,
    input  wire logic          program_start_i,
    input  wire logic          erase_done_i,
    input  wire logic          program_done_i,
    input  wire logic          autoselect_enter_i,
    input  wire logic          autoselect_exit_i,
    // read side
    input  wire logic          rd_i,
    input  wire logic [SW-1:0] rd_sector_i,
    // acceleration supply level
    input  wire logic [1:0]    accel_level_i,
    // status and mode outputs
    output logic               polling_status_bit_o,
    output logic               toggle_status_bit_o,
    output logic               sector_toggle_status_bit_o,
    output logic               erase_run_o,
    output logic               program_run_o,
    output logic               erase_suspended_o,
    output logic               program_suspended_o,
    output logic               read_status_o,
    output logic               autoselect_o,
    output logic               accel_mode_o,
    output logic               sectors_locked_o
);
    fsr_pkg::fsr_state_e ers_reg;
    fsr_pkg::fsr_state_e prg_reg;
    logic [$clog2(SEL_WIN_CYC+1)-1:0] win_reg;
    logic [BW-1:0] ers_bank_reg;
    logic          chip_reg;
    logic          ers_pend_reg;
    logic          prg_pend_reg;
    logic          prg_in_susp_reg;
    logic          ers_lat_done;
    logic          prg_lat_done;
    logic          erase_hit;
    logic          prog_hit;
    logic          rd_q_reg;
    logic          is_susp;
    logic          is_res;
    logic          ers_lat_start;
    logic          prg_lat_start;
    logic          ers_mark_set;
    logic          prg_accept;
    localparam int ERS_LAT_MAX = ERS_CYC + 2;
    localparam int PRG_LAT_MAX = PRG_CYC + 2;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);

    assign is_susp = wr_i && wr_data_i == fsr_pkg::FSR_CMD_SUSPEND;
    assign is_res  = wr_i && wr_data_i == fsr_pkg::FSR_CMD_RESUME;

    // erase-side suspend request: matching bank, not chip erase
    logic ers_susp_req;
    assign ers_susp_req = is_susp && !chip_reg && wr_bank_i == ers_bank_reg
                          && prg_reg != fsr_pkg::FSR_PROGRAM;
    assign ers_lat_start = ers_susp_req && ers_reg == fsr_pkg::FSR_ERASING && !ers_pend_reg;
    assign prg_lat_start = is_susp && prg_reg == fsr_pkg::FSR_PROGRAM && !prg_pend_reg;
    // refused starts must leave no stale sector mark
    assign ers_mark_set  = (sector_erase_start_i && ers_reg == fsr_pkg::FSR_IDLE
                            && !sectors_locked_o)
                           || (erase_sector_add_i && ers_reg == fsr_pkg::FSR_SEL_WIN);
    assign prg_accept    = program_start_i && !sectors_locked_o && prg_reg == fsr_pkg::FSR_IDLE
                           && (ers_reg == fsr_pkg::FSR_IDLE || ers_reg == fsr_pkg::FSR_ERS_SUSP);

    fsr_latency_timer #(.CYCLES(ERS_CYC)) u_ers_lat (
        .clk_sys_i (clk_sys_i),
        .rst_b_i   (rst_b_i),
        .start_i   (ers_lat_start),
        .abort_i   (erase_done_i),
        .done_o    (ers_lat_done)
    );

    fsr_latency_timer #(.CYCLES(PRG_CYC)) u_prg_lat (
        .clk_sys_i (clk_sys_i),
        .rst_b_i   (rst_b_i),
        .start_i   (prg_lat_start),
        .abort_i   (program_done_i),
        .done_o    (prg_lat_done)
    );

    fsr_sector_mark #(.SECTORS(SECTORS), .SW(SW)) u_ers_mark (
        .clk_sys_i      (clk_sys_i),
        .rst_b_i        (rst_b_i),
        .set_i          (ers_mark_set),
        .set_sector_i   (wr_sector_i),
        .clear_all_i    (erase_done_i),
        .query_sector_i (rd_sector_i),
        .hit_o          (erase_hit)
    );

    fsr_sector_mark #(.SECTORS(SECTORS), .SW(SW)) u_prg_mark (
        .clk_sys_i      (clk_sys_i),
        .rst_b_i        (rst_b_i),
        .set_i          (prg_accept),
        .set_sector_i   (wr_sector_i),
        .clear_all_i    (program_done_i),
        .query_sector_i (rd_sector_i),
        .hit_o          (prog_hit)
    );

    // erase state machine
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            ers_reg      <= fsr_pkg::FSR_IDLE;
            ers_pend_reg <= 1'b0;
            chip_reg     <= 1'b0;
            ers_bank_reg <= '0;
            win_reg      <= '0;
        end else begin
            case (ers_reg)
                fsr_pkg::FSR_IDLE: begin
                    if ((sector_erase_start_i || chip_erase_start_i) && !sectors_locked_o) begin
                        ers_reg      <= fsr_pkg::FSR_SEL_WIN;
                        chip_reg     <= chip_erase_start_i;
                        ers_bank_reg <= wr_bank_i;
                        win_reg      <= ($bits(win_reg))'(SEL_WIN_CYC);
                    end
                end
                fsr_pkg::FSR_SEL_WIN: begin
                    if (ers_susp_req) begin
                        ers_reg <= fsr_pkg::FSR_ERS_SUSP;
                    end else if (erase_sector_add_i) begin
                        win_reg <= ($bits(win_reg))'(SEL_WIN_CYC);
                    end else if (win_reg == '0) begin
                        ers_reg <= fsr_pkg::FSR_ERASING;
                    end else begin
                        win_reg <= win_reg - 1'b1;
                    end
                end
                fsr_pkg::FSR_ERASING: begin
                    if (erase_done_i) begin
                        ers_reg      <= fsr_pkg::FSR_IDLE;
                        ers_pend_reg <= 1'b0;
                    end else if (ers_lat_done) begin
                        ers_reg      <= fsr_pkg::FSR_ERS_SUSP;
                        ers_pend_reg <= 1'b0;
                    end else if (ers_susp_req) begin
                        ers_pend_reg <= 1'b1;
                    end
                end
                fsr_pkg::FSR_ERS_SUSP: begin
                    // resume only with matching bank, and not while a program is busy
                    if (is_res && wr_bank_i == ers_bank_reg
                        && prg_reg == fsr_pkg::FSR_IDLE) begin
                        ers_reg <= fsr_pkg::FSR_ERASING;
                    end
                end
                default: ers_reg <= fsr_pkg::FSR_IDLE;
            endcase
        end
    end

    // program state machine; a program in erase suspend nests here
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            prg_reg         <= fsr_pkg::FSR_IDLE;
            prg_pend_reg    <= 1'b0;
            prg_in_susp_reg <= 1'b0;
        end else begin
            case (prg_reg)
                fsr_pkg::FSR_IDLE: begin
                    if (prg_accept) begin
                        prg_reg         <= fsr_pkg::FSR_PROGRAM;
                        prg_in_susp_reg <= ers_reg == fsr_pkg::FSR_ERS_SUSP;
                    end
                end
                fsr_pkg::FSR_PROGRAM: begin
                    if (program_done_i) begin
                        prg_reg      <= fsr_pkg::FSR_IDLE;
                        prg_pend_reg <= 1'b0;
                    end else if (prg_lat_done) begin
                        prg_reg      <= fsr_pkg::FSR_PRG_SUSP;
                        prg_pend_reg <= 1'b0;
                    end else if (is_susp) begin
                        prg_pend_reg <= 1'b1;
                    end
                end
                fsr_pkg::FSR_PRG_SUSP: begin
                    if (is_res) begin
                        prg_reg <= fsr_pkg::FSR_PROGRAM;
                    end
                end
                default: prg_reg <= fsr_pkg::FSR_IDLE;
            endcase
        end
    end

    // identification-read mode only from a suspended state
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            autoselect_o <= 1'b0;
        end else if (autoselect_exit_i) begin
            autoselect_o <= 1'b0;
        end else if (autoselect_enter_i && (ers_reg == fsr_pkg::FSR_ERS_SUSP
                     || prg_reg == fsr_pkg::FSR_PRG_SUSP)) begin
            autoselect_o <= 1'b1;
        end
    end

    // acceleration: enter on high level, leave only when no operation runs
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            accel_mode_o     <= 1'b0;
            sectors_locked_o <= 1'b0;
        end else begin
            sectors_locked_o <= accel_level_i == fsr_pkg::FSR_ACCEL_LOW;
            if (accel_level_i == fsr_pkg::FSR_ACCEL_HIGH) begin
                accel_mode_o <= 1'b1;
            end else if (ers_reg == fsr_pkg::FSR_IDLE && prg_reg == fsr_pkg::FSR_IDLE) begin
                accel_mode_o <= 1'b0;
            end
        end
    end

    // status bits and read routing, aligned with the registered sector lookup
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            rd_q_reg                   <= 1'b0;
            read_status_o              <= 1'b0;
            polling_status_bit_o       <= fsr_pkg::FSR_POLL_DONE;
            toggle_status_bit_o        <= 1'b0;
            sector_toggle_status_bit_o <= 1'b0;
            erase_run_o                <= 1'b0;
            program_run_o              <= 1'b0;
            erase_suspended_o          <= 1'b0;
            program_suspended_o        <= 1'b0;
        end else begin
            rd_q_reg <= rd_i;
            // status for suspended or busy sectors; array data elsewhere
            read_status_o <= rd_q_reg && !autoselect_o
                             && ((erase_hit && ers_reg != fsr_pkg::FSR_IDLE)
                                 || (prog_hit && prg_reg != fsr_pkg::FSR_IDLE));
            polling_status_bit_o <= (ers_reg == fsr_pkg::FSR_ERASING
                                     || ers_reg == fsr_pkg::FSR_SEL_WIN)
                                    ? fsr_pkg::FSR_POLL_BUSY : fsr_pkg::FSR_POLL_DONE;
            if (rd_q_reg && (ers_reg == fsr_pkg::FSR_ERASING || prg_reg == fsr_pkg::FSR_PROGRAM)) begin
                toggle_status_bit_o <= !toggle_status_bit_o;
            end
            if (rd_q_reg && erase_hit && ers_reg != fsr_pkg::FSR_IDLE) begin
                sector_toggle_status_bit_o <= !sector_toggle_status_bit_o;
            end
            erase_run_o         <= ers_reg == fsr_pkg::FSR_ERASING;
            program_run_o       <= prg_reg == fsr_pkg::FSR_PROGRAM;
            erase_suspended_o   <= ers_reg == fsr_pkg::FSR_ERS_SUSP;
            program_suspended_o <= prg_reg == fsr_pkg::FSR_PRG_SUSP;
        end
    end

    // checks
    sequence s_win_susp;
        ers_reg == fsr_pkg::FSR_SEL_WIN && ers_susp_req;
    endsequence

    a_window_suspend: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        s_win_susp |=> ers_reg == fsr_pkg::FSR_ERS_SUSP)
        else $error("erase not suspended in select window");

    a_chip_no_susp: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        chip_reg && ers_reg == fsr_pkg::FSR_ERASING |=> ers_reg != fsr_pkg::FSR_ERS_SUSP)
        else $error("chip erase was suspended");

    a_erase_latency: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        ers_lat_start |-> ##[1:ERS_LAT_MAX] (ers_reg != fsr_pkg::FSR_ERASING))
        else $error("erase suspend latency exceeded");

    a_prog_latency: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        prg_lat_start |-> ##[1:PRG_LAT_MAX] (prg_reg != fsr_pkg::FSR_PROGRAM))
        else $error("program suspend latency exceeded");

    a_poll_busy: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        ers_reg == fsr_pkg::FSR_ERASING |=> polling_status_bit_o == fsr_pkg::FSR_POLL_BUSY)
        else $error("polling bit not busy during erase");

    a_resume_ignored: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        is_res && prg_reg == fsr_pkg::FSR_PROGRAM |=> prg_reg != fsr_pkg::FSR_PRG_SUSP)
        else $error("stray resume changed program state");

    a_lock_low: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        accel_level_i == fsr_pkg::FSR_ACCEL_LOW |=> sectors_locked_o)
        else $error("sectors not locked at low level");

    a_accel_enter: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        accel_level_i == fsr_pkg::FSR_ACCEL_HIGH |=> accel_mode_o)
        else $error("accelerated mode not entered");

    a_prog_resume: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        is_res && prg_reg == fsr_pkg::FSR_PRG_SUSP |=> prg_reg == fsr_pkg::FSR_PROGRAM)
        else $error("program not resumed");

    sequence s_marked_read;
        rd_i && ers_reg == fsr_pkg::FSR_ERS_SUSP && !autoselect_o
        ##1 erase_hit && ers_reg == fsr_pkg::FSR_ERS_SUSP && !autoselect_o;
    endsequence

    sequence s_clear_read;
        rd_i ##1 !erase_hit && !prog_hit;
    endsequence

    a_susp_status: assert property (s_marked_read |=> read_status_o)
        else $error("status not given for suspended sector");

    a_clear_read: assert property (s_clear_read |=> !read_status_o)
        else $error("status given for unmarked sector");

    a_nest_return: assert property (
        prg_in_susp_reg && prg_reg == fsr_pkg::FSR_PROGRAM && program_done_i
        |=> prg_reg == fsr_pkg::FSR_IDLE && ers_reg == fsr_pkg::FSR_ERS_SUSP)
        else $error("nested program left erase suspend");

    a_erase_resume: assert property (
        ers_reg == fsr_pkg::FSR_ERS_SUSP && is_res && wr_bank_i == ers_bank_reg
        && prg_reg == fsr_pkg::FSR_IDLE |=> ers_reg == fsr_pkg::FSR_ERASING)
        else $error("erase not resumed");

    a_ident_enter: assert property (
        autoselect_enter_i && !autoselect_exit_i && ers_reg == fsr_pkg::FSR_ERS_SUSP
        |=> autoselect_o)
        else $error("identification read refused in erase suspend");

    a_accel_exit: assert property (
        accel_level_i != fsr_pkg::FSR_ACCEL_HIGH && ers_reg == fsr_pkg::FSR_IDLE
        && prg_reg == fsr_pkg::FSR_IDLE |=> !accel_mode_o)
        else $error("accelerated mode kept when idle");

    a_lock_refuse: assert property (
        sectors_locked_o && prg_reg == fsr_pkg::FSR_IDLE |=> prg_reg == fsr_pkg::FSR_IDLE)
        else $error("program started on locked sectors");
endmodule // fsr_control

// File: sim/fsr_host_model.sv
// fsr_host_model: host side issuing single-cycle suspend and resume writes
// assumes one bench process calls cmd; addresses stay put between writes
`timescale 1ns/1ps
module fsr_host_model #(
    parameter int GAP = 4
) (
    // clock
    input  wire logic   clk_sys_i,
    // command bus
    output logic        wr_o,
    output logic [15:0] data_o,
    output logic [1:0]  bank_o,
    output logic [3:0]  sector_o
);
    int since_res = 1000;
    initial begin
        wr_o = 1'b0;
        data_o = 16'h0000;
        bank_o = 2'h0;
        sector_o = 4'h0;
    end
    always @(posedge clk_sys_i) begin
        if (wr_o && data_o == fsr_pkg::FSR_CMD_RESUME) since_res <= 0;
        else since_res <= since_res + 1;
    end
    // stb low only places the address, ahead of an engine start pulse
    // single-cycle writes only; a suspend waits until GAP cycles have passed since the last resume
    task automatic cmd(input logic stb, input logic [15:0] d, input logic [1:0] b,
                       input logic [3:0] s);
        @(posedge clk_sys_i);
        while (stb && d == fsr_pkg::FSR_CMD_SUSPEND && since_res < GAP) @(posedge clk_sys_i);
        wr_o <= stb;
        data_o <= d;
        bank_o <= b;
        sector_o <= s;
        @(posedge clk_sys_i);
        wr_o <= 1'b0;
    endtask
endmodule // fsr_host_model

// File: sim/tb_top.sv
// tb_top: self-checking bench for fsr_control driven by a host model
// assumes a 10 MHz clock; window and latency counts are shortened by parameter
`timescale 1ns/1ps
module tb_top;
    localparam int ERS = 20;
    localparam int PRG = 10;
    localparam logic [15:0] SUSP = fsr_pkg::FSR_CMD_SUSPEND;
    localparam logic [15:0] RES  = fsr_pkg::FSR_CMD_RESUME;
    logic        clk_sys_i;
    logic        rst_b_i;
    logic [7:0]  eng;
    logic        rd;
    logic [3:0]  rd_sec;
    logic [1:0]  acc;
    logic        wr;
    logic [15:0] wr_data;
    logic [1:0]  wr_bank;
    logic [3:0]  wr_sec;
    wire  [10:0] o;
    int          error_cnt = 0;
    int          checks = 0;
    int          n;

    fsr_host_model #(.GAP(4)) host (
        .clk_sys_i (clk_sys_i), .wr_o (wr), .data_o (wr_data),
        .bank_o    (wr_bank), .sector_o (wr_sec)
    );
    fsr_control #(.SEL_WIN_CYC(5), .ERS_CYC(ERS), .PRG_CYC(PRG)) dut (
        .clk_sys_i (clk_sys_i), .rst_b_i (rst_b_i), .wr_i (wr), .wr_data_i (wr_data),
        .wr_bank_i (wr_bank), .wr_sector_i (wr_sec),
        .sector_erase_start_i (eng[0]), .chip_erase_start_i (eng[1]),
        .erase_sector_add_i (eng[2]), .program_start_i (eng[3]),
        .erase_done_i (eng[4]), .program_done_i (eng[5]),
        .autoselect_enter_i (eng[6]), .autoselect_exit_i (eng[7]),
        .rd_i (rd), .rd_sector_i (rd_sec), .accel_level_i (acc),
        .polling_status_bit_o (o[0]), .toggle_status_bit_o (o[1]),
        .sector_toggle_status_bit_o (o[2]), .erase_run_o (o[3]), .program_run_o (o[4]),
        .erase_suspended_o (o[5]), .program_suspended_o (o[6]), .read_status_o (o[7]),
        .autoselect_o (o[8]), .accel_mode_o (o[9]), .sectors_locked_o (o[10])
    );

    initial begin
        clk_sys_i = 1'b0;
        forever #50 clk_sys_i = ~clk_sys_i;
    end
    task automatic chk(input logic [10:0] got, input logic [10:0] exp);
        checks++;
        if (got !== exp) begin
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
            error_cnt++;
        end
    endtask
    // bounded wait on one status output, sampled mid-cycle
    task automatic wt(input int k, input logic v, input int lim);
        n = 0;
        @(negedge clk_sys_i);
        while (o[k] !== v && n < lim) begin
            @(negedge clk_sys_i);
            n++;
        end
    endtask
    task automatic pulse(input int k);
        @(posedge clk_sys_i);
        eng[k] <= 1'b1;
        @(posedge clk_sys_i);
        eng[k] <= 1'b0;
    endtask
    task automatic rdck(input logic [3:0] s, input logic exp);
        logic seen;
        @(posedge clk_sys_i);
        rd <= 1'b1;
        rd_sec <= s;
        @(posedge clk_sys_i);
        rd <= 1'b0;
        seen = 1'b0;
        @(posedge clk_sys_i);
        repeat (2) begin
            @(negedge clk_sys_i);
            seen = seen | o[7];
        end
        chk(seen, exp);
    endtask
    task automatic t_window;
        logic [1:0] tg;
        host.cmd(0, 16'h0000, 2'h1, 4'h3);
        pulse(0);
        wt(0, 0, 3);
        chk(o[0], 0);
        host.cmd(1, SUSP, 2'h1, 4'h3);
        wt(5, 1, 3);
        chk({o[5], o[0]}, 2'b11);
        rdck(4'h3, 1);
        rdck(4'h5, 0);
        host.cmd(1, RES, 2'h1, 4'h3);
        wt(3, 1, 4);
        host.cmd(1, RES, 2'h1, 4'h3);
        repeat (3) @(negedge clk_sys_i);
        chk(o[5:3], 3'b001);
        tg = ~o[2:1];
        rdck(4'h3, 1);
        chk(o[2:1], tg);
        $display("t_window done");
    endtask
    task automatic t_run;
        repeat (10) @(posedge clk_sys_i);
        host.cmd(1, SUSP, 2'h2, 4'h3);
        repeat (ERS + 4) @(negedge clk_sys_i);
        chk(o[5], 0);
        host.cmd(1, SUSP, 2'h1, 4'h3);
        wt(5, 1, ERS + 2);
        chk(o[5], 1);
        host.cmd(0, 16'h0000, 2'h1, 4'h5);
        pulse(3);
        wt(4, 1, 3);
        chk(o[4], 1);
        host.cmd(1, SUSP, 2'h0, 4'h9);
        wt(6, 1, PRG + 2);
        chk(o[6], 1);
        rdck(4'h3, 1);
        host.cmd(1, RES, 2'h0, 4'h0);
        wt(6, 0, 4);
        chk(o[6:4], 3'b011);
        pulse(5);
        wt(4, 0, 3);
        chk(o[5:4], 2'b10);
        pulse(6);
        wt(8, 1, 3);
        chk(o[8], 1);
        pulse(7);
        host.cmd(1, RES, 2'h1, 4'h3);
        wt(3, 1, 4);
        chk({o[8], o[5], o[3]}, 3'b001);
        pulse(4);
        wt(0, 1, 3);
        chk({o[3], o[0]}, 2'b01);
        $display("t_run done");
    endtask
    task automatic t_chip;
        host.cmd(0, 16'h0000, 2'h1, 4'h3);
        pulse(1);
        host.cmd(1, SUSP, 2'h1, 4'h3);
        repeat (ERS + 4) @(negedge clk_sys_i);
        chk({o[5], o[0]}, 2'b00);
        pulse(4);
        wt(0, 1, 3);
        chk(o[0], 1);
        $display("t_chip done");
    endtask
    task automatic t_prog;
        host.cmd(0, 16'h0000, 2'h2, 4'h7);
        pulse(3);
        wt(4, 1, 3);
        host.cmd(1, SUSP, 2'h3, 4'hC);
        wt(6, 1, PRG + 2);
        chk(o[6], 1);
        rdck(4'h2, 0);
        pulse(6);
        wt(8, 1, 3);
        chk(o[8], 1);
        pulse(7);
        wt(8, 0, 3);
        chk({o[8], o[6]}, 2'b01);
        host.cmd(1, RES, 2'h1, 4'h1);
        wt(4, 1, 4);
        host.cmd(1, RES, 2'h1, 4'h1);
        repeat (3) @(negedge clk_sys_i);
        chk(o[6:4], 3'b001);
        host.cmd(1, SUSP, 2'h0, 4'h0);
        wt(6, 1, PRG + 2);
        chk(o[6], 1);
        host.cmd(1, RES, 2'h0, 4'h0);
        wt(4, 1, 4);
        pulse(5);
        wt(4, 0, 3);
        chk(o[6:4], 3'b000);
        $display("t_prog done");
    endtask
    task automatic t_idle;
        host.cmd(1, SUSP, 2'h0, 4'h0);
        host.cmd(1, RES, 2'h0, 4'h0);
        repeat (3) @(negedge clk_sys_i);
        chk({o[6:3], o[0]}, 5'b00001);
        $display("t_idle done");
    endtask
    task automatic t_accel;
        @(posedge clk_sys_i);
        acc <= 2'h2;
        wt(9, 1, 3);
        chk(o[9], 1);
        host.cmd(0, 16'h0000, 2'h0, 4'h1);
        pulse(3);
        acc <= 2'h1;
        repeat (3) @(negedge clk_sys_i);
        chk({o[9], o[4]}, 2'b11);
        pulse(5);
        wt(9, 0, 3);
        chk(o[9], 0);
        @(posedge clk_sys_i);
        acc <= 2'h0;
        wt(10, 1, 3);
        chk(o[10], 1);
        pulse(3);
        repeat (3) @(negedge clk_sys_i);
        chk(o[4], 0);
        $display("t_accel done");
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        rst_b_i = 1'b0;
        eng = 8'h00;
        rd = 1'b0;
        rd_sec = 4'h0;
        acc = 2'h1;
        repeat (20) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        repeat (2) @(negedge clk_sys_i);
        chk(o, 11'h001);
        t_window();
        t_run();
        t_chip();
        t_prog();
        t_idle();
        t_accel();
        conclude();
    end
    // the tests need well under 2000 cycles
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        error_cnt++;
        conclude();
    end
endmodule // tb_top
